// *** shared/tmc_defs.vh ***
// Purpose: Constants for the timer control register block
// Assumes: Byte-wide plain register port, 50 MHz core clock
// Notes: Offsets are byte addresses on the register port
`ifndef TMC_DEFS_VH
`define TMC_DEFS_VH

// ======================================================
// Register offsets
`define TMC_OFS_CTL0 32'hFFFFF600
`define TMC_OFS_CTL1 32'hFFFFF601
`define TMC_OFS_IOC0 32'h0FFFF602
`define TMC_OFS_STAT 32'hFFFFF605
`define TMC_OFS_CNTL 32'hFFFFF606
`define TMC_OFS_CNTH 32'hFFFFF607

// ======================================================
// Field positions
`define TMC_CTL0_RUN 7
`define TMC_CTL0_CKS_HI 2
`define TMC_CTL0_CKS_LO 0
`define TMC_CTL1_TRIG 6
`define TMC_CTL1_EEE 5
`define TMC_CTL1_MD_HI 2
`define TMC_CTL1_MD_LO 0
`define TMC_STAT_OVF 0

// ======================================================
// Reset values
`define TMC_RST_REG 8'h00
`define TMC_RST_CNT 16'hFFFF
`define TMC_CNT_IDLE_READ 16'h0000

// ======================================================
// Timer modes
`define TMC_MD_INTERVAL 3'h0
`define TMC_MD_EVENT 3'h1
`define TMC_MD_EXT_TRIG 3'h2
`define TMC_MD_ONE_SHOT 3'h3
`define TMC_MD_PWM 3'h4
`define TMC_MD_FREE_RUN 3'h5
`define TMC_MD_PULSE_MEAS 3'h6
`define TMC_MD_SIX_PWM 3'h7

// ======================================================
// Prescaler
`define TMC_PRESC_W 8

`endif

// *** core/tmc_prescaler.v ***
// Purpose: Peripheral clock divider giving a one-cycle count enable
// Assumes: Cleared while the timer is stopped
// Notes: Code n gives one pulse every 2^(n+1) clocks
`include "tmc_defs.vh"
`default_nettype none

module tmc_prescaler (
	input wire core_clk,
	input wire rst,
	input wire run,
	input wire [2:0] select,
	output reg tick
);

reg [`TMC_PRESC_W-1:0] div_cnt;
reg [`TMC_PRESC_W-1:0] mask;
integer i;

// ======================================================
// Mask of the low bits that must all be ones
always @*
begin
	mask = {`TMC_PRESC_W{1'b0}};
	for (i = 0; i < `TMC_PRESC_W; i = i + 1)
	begin
		if (i <= select)
		begin
			mask[i] = 1'b1;
		end
	end
end

// ======================================================
// Divider; restarts on each run so the first tick is a full period
always @(posedge core_clk)
begin
	if (rst || !run)
	begin
		div_cnt <= {`TMC_PRESC_W{1'b0}};
		tick <= 1'b0;
	end
	else
	begin
		div_cnt <= div_cnt + 8'h01;
		tick <= ((div_cnt & mask) == mask);
	end
end

endmodule

`default_nettype wire

// *** core/tmc_timer.v ***
// Purpose: Control registers, count source and output control of a 16-bit timer
// Assumes: Plain register port, byte data, read data one cycle after the strobe
// Notes: Mode-specific compare and capture logic lives outside this block
//
// The plain strobed port was chosen for this implementation.
`include "tmc_defs.vh"
`default_nettype none

// Functional notes
// - Run bit 0 holds the timer stopped and reset; 1 starts it.
// - Clearing run resets overflow flag and counter together; the pins return to their start level one clock later.
// - Clock select codes 0..7 pick peripheral clock divided by 2..256.
// - Rewriting control 0 with its current value never disturbs operation.
// - Writing 1 to software trigger acts as a valid external trigger.
// - Software trigger bit always reads as zero.
// - Software trigger ignored outside one-shot and external trigger modes.
// - Event enable picks internal count clock or external event edges.
// - Mode codes 0..7 select the eight timer operating modes.
// - Event count mode always counts the external event input.
// - Level bit 0 starts the pin high; level bit 1 starts it low.
// - Enable 0 drives the level bit onto the pin; enable 1 the pulse.
// - Stopped and disabled, a level change reaches the pin one clock later.
// - Three control registers, 8 bits, byte access, reset to zero.
// - Stopped counter holds all ones internally and reads as zero.
module tmc_timer (
	input wire core_clk,
	input wire rst,
	input wire [31:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [7:0] reg_rdata,
	input wire event_count_input,
	output reg [3:0] timer_output_pin,
	output reg count_tick,
	output reg trigger_pulse,
	output wire overflow_flag,
	output wire [2:0] timer_mode
);

// ======================================================
// Register state

reg run_enable_bit;
reg [2:0] count_clock_select;
reg external_event_enable_bit;
reg [2:0] timer_mode_select;
reg [7:0] output_control;
reg ovf;

wire sel_ctl0;
wire sel_ctl1;
wire sel_ioc0;
wire sel_stat;
wire sel_cntl;
wire sel_cnth;

assign sel_ctl0 = (reg_addr == `TMC_OFS_CTL0);
assign sel_ctl1 = (reg_addr == `TMC_OFS_CTL1);
assign sel_ioc0 = (reg_addr == `TMC_OFS_IOC0);
assign sel_stat = (reg_addr == `TMC_OFS_STAT);
assign sel_cntl = (reg_addr == `TMC_OFS_CNTL);
assign sel_cnth = (reg_addr == `TMC_OFS_CNTH);

assign overflow_flag = ovf;
assign timer_mode = timer_mode_select;

// ======================================================
// Timer core state

reg [15:0] counter;
reg started;
reg armed;
reg [3:0] pulse_toggle;

wire presc_tick;
wire use_external;
wire trig_mode;
wire ovf_mode;
wire sw_trigger;
wire tick_now;
wire wrap;
wire [15:0] counter_view;

// ======================================================
// Control register writes

always @(posedge core_clk)
begin
	if (rst)
	begin
		run_enable_bit <= 1'b0;
		count_clock_select <= 3'h0;
		external_event_enable_bit <= 1'b0;
		timer_mode_select <= 3'h0;
		output_control <= `TMC_RST_REG;
	end
	else
	begin
		if (reg_wr && sel_ctl0)
		begin
			// Same-value rewrite keeps running: nothing restarts on a 1 -> 1 write
			run_enable_bit <= reg_wdata[`TMC_CTL0_RUN];
			count_clock_select <= reg_wdata[`TMC_CTL0_CKS_HI:`TMC_CTL0_CKS_LO];
		end
		if (reg_wr && sel_ctl1)
		begin
			external_event_enable_bit <= reg_wdata[`TMC_CTL1_EEE];
			timer_mode_select <= reg_wdata[`TMC_CTL1_MD_HI:`TMC_CTL1_MD_LO];
		end
		if (reg_wr && sel_ioc0)
		begin
			output_control <= reg_wdata;
		end
	end
end

// ======================================================
// Software trigger: a write strobe only, never stored

assign trig_mode = (timer_mode_select == `TMC_MD_ONE_SHOT) ||
	(timer_mode_select == `TMC_MD_EXT_TRIG);

assign sw_trigger = reg_wr && sel_ctl1 &&
	reg_wdata[`TMC_CTL1_TRIG] && trig_mode && run_enable_bit;

always @(posedge core_clk)
begin
	if (rst)
	begin
		trigger_pulse <= 1'b0;
	end
	else
	begin
		trigger_pulse <= sw_trigger;
	end
end

// ======================================================
// Count source

tmc_prescaler u_presc (
	.core_clk(core_clk),
	.rst(rst),
	.run(run_enable_bit),
	.select(count_clock_select),
	.tick(presc_tick)
);

reg evt_meta;
reg evt_sync;
reg evt_prev;

// Pin is asynchronous to core_clk; two stages before edge detection
always @(posedge core_clk)
begin
	if (rst)
	begin
		evt_meta <= 1'b0;
		evt_sync <= 1'b0;
		evt_prev <= 1'b0;
	end
	else
	begin
		evt_meta <= event_count_input;
		evt_sync <= evt_meta;
		evt_prev <= evt_sync;
	end
end

assign use_external = external_event_enable_bit ||
	(timer_mode_select == `TMC_MD_EVENT);

// Rising edges only; edge selection is handled elsewhere
assign tick_now = run_enable_bit &&
	(use_external ? (evt_sync && !evt_prev) : presc_tick);

always @(posedge core_clk)
begin
	if (rst)
	begin
		count_tick <= 1'b0;
	end
	else
	begin
		count_tick <= tick_now;
	end
end

// ======================================================
// 16-bit counter

assign wrap = tick_now && started && (counter == `TMC_RST_CNT);
assign ovf_mode = (timer_mode_select == `TMC_MD_FREE_RUN) ||
	(timer_mode_select == `TMC_MD_PULSE_MEAS);

always @(posedge core_clk)
begin
	if (rst || !run_enable_bit)
	begin
		// Held at all ones for as long as run is low, not only on the edge
		counter <= `TMC_RST_CNT;
		started <= 1'b0;
	end
	else if (tick_now)
	begin
		counter <= counter + 16'h0001;
		started <= 1'b1;
	end
end

// ======================================================
// Overflow flag: set wins over a software clear

always @(posedge core_clk)
begin
	if (rst || !run_enable_bit)
	begin
		ovf <= 1'b0;
	end
	else if (wrap && ovf_mode)
	begin
		ovf <= 1'b1;
	end
	else if (reg_wr && sel_stat && !reg_wdata[`TMC_STAT_OVF])
	begin
		ovf <= 1'b0;
	end
end

// ======================================================
// Trigger arming for the triggered pulse modes

always @(posedge core_clk)
begin
	if (rst || !run_enable_bit)
	begin
		armed <= 1'b0;
	end
	else if (sw_trigger)
	begin
		armed <= 1'b1;
	end
end

// ======================================================
// Output control, one slice per channel

genvar ch;
generate
	for (ch = 0; ch < 4; ch = ch + 1)
	begin : g_chan
		wire oe;
		wire ol;
		wire pulse_go;
		assign oe = output_control[2 * ch];
		assign ol = output_control[2 * ch + 1];
		assign pulse_go = wrap && (!trig_mode || armed);

		always @(posedge core_clk)
		begin
			if (rst || !run_enable_bit)
			begin
				pulse_toggle[ch] <= 1'b0;
			end
			else if (pulse_go)
			begin
				pulse_toggle[ch] <= ~pulse_toggle[ch];
			end
		end

		// Registered pin: a level change shows one clock later
		always @(posedge core_clk)
		begin
			if (rst)
			begin
				timer_output_pin[ch] <= 1'b0;
			end
			else if (oe)
			begin
				timer_output_pin[ch] <= ~ol ^ pulse_toggle[ch];
			end
			else
			begin
				timer_output_pin[ch] <= ol;
			end
		end
	end
endgenerate

// ======================================================
// Register reads

assign counter_view = run_enable_bit ? counter : `TMC_CNT_IDLE_READ;

always @(posedge core_clk)
begin
	if (rst)
	begin
		reg_rdata <= 8'h00;
	end
	else if (reg_rd)
	begin
		if (sel_ctl0)
		begin
			reg_rdata <= {run_enable_bit, 4'h0, count_clock_select};
		end
		else if (sel_ctl1)
		begin
			// Trigger bit and reserved bits read as zero
			reg_rdata <= {2'b00, external_event_enable_bit, 2'b00, timer_mode_select};
		end
		else if (sel_ioc0)
		begin
			reg_rdata <= output_control;
		end
		else if (sel_stat)
		begin
			reg_rdata <= {7'h00, ovf};
		end
		else if (sel_cntl)
		begin
			reg_rdata <= counter_view[7:0];
		end
		else if (sel_cnth)
		begin
			reg_rdata <= counter_view[15:8];
		end
		else
		begin
			reg_rdata <= 8'h00;
		end
	end
	else
	begin
		reg_rdata <= 8'h00;
	end
end

endmodule

`default_nettype wire

// *** bench/tmc_timer_checker.sv ***
// Purpose: Port assertions for the timer control block
// Assumes: Shadows follow every register write
// Notes: Bound to tmc_timer below the module
`include "tmc_defs.vh"
`default_nettype none
module tmc_timer_checker (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [31:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic event_count_input,
	input wire logic [3:0] timer_output_pin,
	input wire logic count_tick,
	input wire logic trigger_pulse,
	input wire logic overflow_flag,
	input wire logic [2:0] timer_mode
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==========
	// Shadows
	logic run_q, eee_q, seen, int_src, trig_wr, md_old, md_new;
	logic [2:0] cks_q;
	logic [7:0] ioc_q;
	logic [15:0] gap;
	logic [3:0] ol, oe;
	assign int_src = !eee_q && timer_mode != `TMC_MD_EVENT;
	assign trig_wr = reg_wr && reg_addr == `TMC_OFS_CTL1 && reg_wdata[6];
	assign md_old = timer_mode[2:1] == 2'h1;
	assign md_new = reg_wdata[2:1] == 2'h1;
	assign ol = {ioc_q[7], ioc_q[5], ioc_q[3], ioc_q[1]};
	assign oe = {ioc_q[6], ioc_q[4], ioc_q[2], ioc_q[0]};
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			run_q <= 1'b0;
			cks_q <= 3'h0;
			eee_q <= 1'b0;
			ioc_q <= 8'h00;
		end
		else if (reg_wr)
		begin
			if (reg_addr == `TMC_OFS_CTL0)
			begin
				run_q <= reg_wdata[7];
				cks_q <= reg_wdata[2:0];
			end
			if (reg_addr == `TMC_OFS_CTL1)
				eee_q <= reg_wdata[5];
			if (reg_addr == `TMC_OFS_IOC0)
				ioc_q <= reg_wdata;
		end
	end
	// Cleared on stop so a new run never measures against an old tick
	always_ff @(posedge core_clk)
	begin
		if (rst || !run_q)
		begin
			gap <= 16'h0000;
			seen <= 1'b0;
		end
		else
		begin
			gap <= count_tick ? 16'h0001 : gap + 16'h0001;
			seen <= seen | count_tick;
		end
	end
	// ==========
	// Properties
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);
	sequence s_stopped;
		(!run_q && $stable(ioc_q)) [*3];
	endsequence
	a_pins_stopped: assert property (s_stopped |-> timer_output_pin == (ol ^ oe))
		else $error("stopped pins wrong");
	a_pins_level: assert property ($stable(ioc_q) |-> ((timer_output_pin ^ ol) & ~oe) == 4'h0)
		else $error("disabled pin wrong");
	a_tick_gap: assert property (count_tick && seen && int_src |-> gap == (16'h0002 << cks_q))
		else $error("tick spacing wrong");
	a_first_tick: assert property ($rose(run_q) && int_src && cks_q == 3'h0 |-> ##[1:6] count_tick)
		else $error("no tick after start");
	a_stop_quiet: assert property ((!run_q) [*2] |=> !count_tick && !overflow_flag)
		else $error("stopped timer active");
	a_ext_count: assert property (run_q && !int_src && $rose(event_count_input) |-> ##[2:6] count_tick)
		else $error("event not counted");
	a_trig_go: assert property (trig_wr && run_q && md_old && md_new |=> trigger_pulse)
		else $error("trigger lost");
	a_trig_skip: assert property (trig_wr && (!run_q || !md_old && !md_new) |=> !trigger_pulse)
		else $error("trigger not ignored");
	a_trig_reads0: assert property (reg_rd && reg_addr == `TMC_OFS_CTL1 |=> !reg_rdata[6])
		else $error("trigger bit read back");
	a_cnt_idle: assert property ((!run_q) [*2] ##0 (reg_rd && reg_addr[31:1] == 31'h7FFFFB03) |=> reg_rdata == 8'h00)
		else $error("idle counter nonzero");
endmodule
bind tmc_timer tmc_timer_checker u_chk (
	.core_clk(core_clk),
	.rst(rst),
	.reg_addr(reg_addr),
	.reg_wdata(reg_wdata),
	.reg_wr(reg_wr),
	.reg_rd(reg_rd),
	.reg_rdata(reg_rdata),
	.event_count_input(event_count_input),
	.timer_output_pin(timer_output_pin),
	.count_tick(count_tick),
	.trigger_pulse(trigger_pulse),
	.overflow_flag(overflow_flag),
	.timer_mode(timer_mode)
);
`default_nettype wire

// *** bench/tmc_timer_tb_top.sv ***
// Purpose: Self-checking bench for the timer control block
// Assumes: 50 MHz clock, synchronous active-high reset
// Notes: Counted count_tick pulses stand in for the hidden counter
`include "tmc_defs.vh"
`default_nettype none
module tmc_timer_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [31:0] c0 = `TMC_OFS_CTL0;
	localparam logic [31:0] c1 = `TMC_OFS_CTL1;
	localparam logic [31:0] io = `TMC_OFS_IOC0;
	localparam logic [31:0] cl = `TMC_OFS_CNTL;
	logic core_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, evt = 0;
	logic [31:0] reg_addr = 32'h0;
	logic [7:0] reg_wdata = 8'h00, reg_rdata, rd_v;
	logic [3:0] pins;
	logic count_tick, trigger_pulse, ovf;
	logic [2:0] timer_mode;
	int fail_count = 0, samples_checked = 0, ticks = 0, cyc = 0, last = 0, gap = 0;
	tmc_timer uut (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .event_count_input(evt), .timer_output_pin(pins),
		.count_tick(count_tick), .trigger_pulse(trigger_pulse), .overflow_flag(ovf), .timer_mode(timer_mode));
	initial forever #10 core_clk = ~core_clk;
	always @(posedge core_clk)
	begin
		cyc <= cyc + 1;
		if (count_tick === 1'b1)
		begin
			ticks <= ticks + 1;
			gap <= cyc - last;
			last <= cyc;
		end
	end
	// ==========
	// Bus and checking tasks
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			fail_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [31:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [31:0] a);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		@(negedge core_clk);
		rd_v = reg_rdata;
	endtask
	task automatic wait_ticks(input int k);
		int i = 0;
		while (ticks < k && i < 3000)
		begin
			@(negedge core_clk);
			i++;
		end
		chk(16'(i < 3000), 16'h0001);
	endtask
	task automatic report_and_stop;
		$display("checks %0d, mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// ==========
	// Scenarios
	task automatic t_reset;
		logic [31:0] al [6] = '{c0, c1, io, cl, `TMC_OFS_CNTH, 32'hFFFFF603};
		wr(32'hFFFFF603, 8'hFF);
		foreach (al[i])
		begin
			rd(al[i]);
			chk(rd_v, 16'h0000);
		end
		chk(pins, 16'h0000);
	endtask
	task automatic t_clock(input int n);
		int t0 = ticks;
		wr(c0, 8'h80 | 8'(n));
		wait_ticks(t0 + 3);
		chk(16'(gap), 16'(2 << n));
		rd(c0);
		chk(rd_v, 16'(8'h80 | 8'(n)));
		if (n > 1)
		begin
			rd(cl);
			chk(rd_v, 16'(ticks - t0 - 1));
		end
		// Same-value rewrite mid-run must leave the divider phase alone
		wr(c0, 8'h80 | 8'(n));
		wait_ticks(ticks + 1);
		chk(16'(gap), 16'(2 << n));
		wr(c0, 8'(n));
		repeat (2) @(posedge core_clk);
		rd(cl);
		chk(rd_v, 16'h0000);
		chk(ovf, 16'h0000);
	endtask
	task automatic t_trigger;
		for (int m = 0; m < 7; m++)
		begin
			wr(c1, 8'(m));
			wr(c0, 8'h80);
			wr(c1, 8'h40 | 8'(m));
			@(negedge core_clk);
			chk(trigger_pulse, 16'(m == 2 || m == 3));
			rd(c1);
			chk(rd_v, 16'(m));
			chk(timer_mode, 16'(m));
			wr(c0, 8'h00);
		end
	endtask
	task automatic t_event;
		logic [7:0] cfg [3] = '{8'h20, 8'h01, 8'h00};
		int t0;
		foreach (cfg[i])
		begin
			wr(c1, cfg[i]);
			// Slowest divider keeps internal ticks out of the window
			wr(c0, 8'h87);
			t0 = ticks;
			repeat (3)
			begin
				repeat (4) @(posedge core_clk);
				evt <= 1'b1;
				repeat (4) @(posedge core_clk);
				evt <= 1'b0;
			end
			repeat (6) @(negedge core_clk);
			chk(16'(ticks - t0), i < 2 ? 16'h0003 : 16'h0000);
			wr(c0, 8'h07);
		end
	endtask
	task automatic t_outputs;
		logic [7:0] pat [6] = '{8'hAA, 8'h55, 8'hFF, 8'h02, 8'h40, 8'h00};
		logic [3:0] e;
		foreach (pat[i])
		begin
			wr(io, pat[i]);
			for (int m = 0; m < 4; m++)
				e[m] = pat[i][2 * m + 1] ^ pat[i][2 * m];
			repeat (2) @(negedge core_clk);
			chk(pins, e);
			rd(io);
			chk(rd_v, pat[i]);
		end
		wr(io, 8'h55);
		wr(c0, 8'h80);
		repeat (20) @(posedge core_clk);
		wr(c0, 8'h00);
		repeat (3) @(negedge core_clk);
		chk(pins, 16'h000F);
	endtask
	initial
	begin
		repeat (3) @(posedge core_clk);
		rst <= 1'b0;
		t_reset;
		for (int n = 0; n < 8; n++)
			t_clock(n);
		t_trigger;
		t_event;
		t_outputs;
		report_and_stop;
	end
	initial
	begin
		repeat (40000) @(posedge core_clk);
		fail_count++;
		report_and_stop;
	end
endmodule
`default_nettype wire
